// ===== rtl/ssrw_map.svh
// Clock and tick timing, input bit positions, reset values and timing counts of the supervisor
`ifndef SSRW_MAP_SVH
`define SSRW_MAP_SVH

`define SSRW_CLK_PERIOD_NS 40
`define SSRW_TICK_NS       1000000
`define SSRW_TICK_CYCLES   ((`SSRW_TICK_NS + `SSRW_CLK_PERIOD_NS - 1) / `SSRW_CLK_PERIOD_NS)

`define SSRW_RST_T0_MS     11'h032
`define SSRW_RST_T1_MS     11'h0C8
`define SSRW_RST_T2_MS     11'h190
`define SSRW_RST_T3_MS     11'h320

`define SSRW_WD_T0_MS      11'h019
`define SSRW_WD_T1_MS      11'h0C8
`define SSRW_WD_T2_MS      11'h578
`define SSRW_WD_SEL_OFF    2'h3

`define SSRW_DEBOUNCE_MS   11'h002

`define SSRW_WD_SEL_RST    2'h0
`define SSRW_RST_SEL_RST   2'h0

`define SSRW_IN_MAIN       0
`define SSRW_IN_SECOND     1
`define SSRW_IN_THIRD      2
`define SSRW_IN_MANUAL     3
`define SSRW_IN_SCL        4
`define SSRW_IN_SDA        5
`define SSRW_IN_WP         6
`define SSRW_IN_WIDTH      7
`define SSRW_SYNC_RST      7'h38

`endif

// ===== rtl/ssrw_pkg.sv
// Types shared by the supervisor modules
package ssrw_pkg;
  typedef logic [10:0] ssrw_ms_t;
  typedef logic [1:0]  ssrw_sel_t;
  typedef logic [14:0] ssrw_pre_t;
  typedef enum logic [1:0] {
    SSRW_BUS_IDLE,
    SSRW_BUS_STARTED,
    SSRW_BUS_CLOCKED
  } ssrw_bus_state_t;
endpackage : ssrw_pkg

// ===== rtl/ssrw_sync.sv
// Three-stage pin synchroniser, change taken once stages two and three agree
`timescale 1ns/100ps
module ssrw_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // Bits where the last two stages agree take the new level
  always_comb begin
    q_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_reg  <= RESET_VAL;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign o_sync = q_reg;
endmodule : ssrw_sync

// ===== rtl/ssrw_supervisor.sv
// Supply supervisor: system reset, supply fail outputs and bus watchdog
//
// Operation
// R1: Start, clock fall, then stop on the bus restarts the watchdog.
// R2: Watchdog expiry without restart drives the timeout output active.
// R3: Timeout output is active low open drain while the timer expired.
// R4: Write-protect high rejects every control write; pin defaults low.
// R5: System reset is asserted at once on power-up and held.
// R6: Reset releases only after main supply stays good a full timeout.
// R7: Manual reset low holds reset, plus one timeout after release.
// R8: Main supply below threshold asserts reset until good for a timeout.
// R9: Second fail output follows the second supply comparator.
// R10: Third fail output is low while third supply is below threshold.
// R11: Third fail output has no timeout delay on recovery.
// R12: Host ties an unused third monitor input to a fixed level.
// R13: Early low-supply output follows main comparator with no delay.
// R14: Any read or write sequence to any address restarts the watchdog.
// R15: Watchdog period comes from two control bits software writes.
// R16: Inputs are synchronised; reset timeout counter loads from setting.
// R17: Reset timeout restarts whenever a reset source returns early.
`timescale 1ns/100ps
`include "ssrw_map.svh"
module ssrw_supervisor #(
  parameter int TICK_CYCLES = `SSRW_TICK_CYCLES
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_reset_n,
  input  wire logic                i_main_supply_ok,
  input  wire logic                i_second_supply_sense,
  input  wire logic                i_third_supply_sense,
  input  wire logic                i_manual_reset_n,
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  input  wire logic                i_write_protect,
  input  wire logic                i_ctrl_write,
  input  wire ssrw_pkg::ssrw_sel_t i_ctrl_wdog_period,
  input  wire ssrw_pkg::ssrw_sel_t i_ctrl_reset_timeout,
  output logic                     o_system_reset_n,
  output logic                     o_early_low_supply_n,
  output logic                     o_second_supply_fail_n,
  output logic                     o_third_supply_fail_n,
  output logic                     o_watchdog_timeout_n,
  output logic                     o_watchdog_oe_n,
  output logic                     o_write_rejected
);
  import ssrw_pkg::*;

  localparam ssrw_pre_t TICK_LAST = 15'(TICK_CYCLES - 1);

  logic [`SSRW_IN_WIDTH-1:0] in_s;
  logic                      main_ok_s;
  logic                      mr_s;
  logic                      scl_s;
  logic                      sda_s;
  logic                      wp_s;

  ssrw_pre_t       free_pre_reg, free_pre_next;
  ssrw_ms_t        dbc_cnt_reg, dbc_cnt_next;
  logic            mr_db_reg, mr_db_next;
  ssrw_pre_t       rst_pre_reg, rst_pre_next;
  ssrw_ms_t        rst_cnt_reg, rst_cnt_next;
  logic            sys_n_reg, sys_n_next;
  logic            cause;
  logic            rst_tick;
  logic            scl_prev_reg, sda_prev_reg;
  ssrw_bus_state_t bus_reg, bus_next;
  logic            start_cond, stop_cond, scl_fall, restart;
  ssrw_pre_t       wd_pre_reg, wd_pre_next;
  ssrw_ms_t        wd_cnt_reg, wd_cnt_next;
  logic            wdo_n_reg, wdo_n_next;
  logic            wd_hold, wd_tick;
  ssrw_sel_t       wd_sel_reg, wd_sel_next;
  ssrw_sel_t       rst_sel_reg, rst_sel_next;
  logic            rej_reg, rej_next;

  function automatic ssrw_pre_t step_pre(input ssrw_pre_t cur,
                                         input logic      clr);
    if (clr || cur == TICK_LAST) begin
      return 15'h0000;
    end
    return cur + 15'h0001;
  endfunction : step_pre

  function automatic ssrw_ms_t reset_ms(input ssrw_sel_t sel);
    case (sel)
      2'h0:    return `SSRW_RST_T0_MS;
      2'h1:    return `SSRW_RST_T1_MS;
      2'h2:    return `SSRW_RST_T2_MS;
      default: return `SSRW_RST_T3_MS;
    endcase
  endfunction : reset_ms

  function automatic ssrw_ms_t wdog_ms(input ssrw_sel_t sel);
    case (sel)
      2'h0:    return `SSRW_WD_T0_MS;
      2'h1:    return `SSRW_WD_T1_MS;
      default: return `SSRW_WD_T2_MS;
    endcase
  endfunction : wdog_ms

  // Pin synchronisers
  ssrw_sync #(
    .WIDTH     (`SSRW_IN_WIDTH),
    .RESET_VAL (`SSRW_SYNC_RST)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    ({i_write_protect, i_sda, i_scl, i_manual_reset_n,
                  i_third_supply_sense, i_second_supply_sense,
                  i_main_supply_ok}), // R16
    .o_sync     (in_s)
  );

  assign main_ok_s = in_s[`SSRW_IN_MAIN];
  assign mr_s      = in_s[`SSRW_IN_MANUAL];
  assign scl_s     = in_s[`SSRW_IN_SCL];
  assign sda_s     = in_s[`SSRW_IN_SDA];
  assign wp_s      = in_s[`SSRW_IN_WP];

  // Manual reset debounce on the free millisecond tick
  always_comb begin
    free_pre_next = step_pre(free_pre_reg, 1'b0);
    dbc_cnt_next  = dbc_cnt_reg;
    mr_db_next    = mr_db_reg;
    if (mr_s == mr_db_reg) begin
      dbc_cnt_next = 11'h000;
    end else if (free_pre_reg == TICK_LAST) begin
      if (dbc_cnt_reg == `SSRW_DEBOUNCE_MS - 11'h001) begin
        mr_db_next   = mr_s;
        dbc_cnt_next = 11'h000;
      end else begin
        dbc_cnt_next = dbc_cnt_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      free_pre_reg <= 15'h0000;
      dbc_cnt_reg  <= 11'h000;
      mr_db_reg    <= 1'b1;
    end else begin
      free_pre_reg <= free_pre_next;
      dbc_cnt_reg  <= dbc_cnt_next;
      mr_db_reg    <= mr_db_next;
    end
  end

  // System reset timing
  assign cause    = !main_ok_s || !mr_db_reg; // R7 R8
  assign rst_tick = rst_pre_reg == TICK_LAST;

  always_comb begin
    rst_pre_next = step_pre(rst_pre_reg, cause || rst_cnt_reg == 11'h000);
    rst_cnt_next = rst_cnt_reg;
    if (cause) begin
      rst_cnt_next = reset_ms(rst_sel_reg); // R16 R17
    end else if (rst_tick && rst_cnt_reg != 11'h000) begin
      rst_cnt_next = rst_cnt_reg - 11'h001;
    end
    sys_n_next = !cause && rst_cnt_reg == 11'h000; // R6
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rst_pre_reg <= 15'h0000;
      rst_cnt_reg <= `SSRW_RST_T0_MS; // R5
      sys_n_reg   <= 1'b0; // R5
    end else begin
      rst_pre_reg <= rst_pre_next;
      rst_cnt_reg <= rst_cnt_next;
      sys_n_reg   <= sys_n_next;
    end
  end

  // Bus activity tracking for watchdog restart
  assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_cond  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign scl_fall   = scl_prev_reg && !scl_s;
  assign restart    = bus_reg == SSRW_BUS_CLOCKED && stop_cond; // R1 R14

  always_comb begin
    bus_next = bus_reg;
    if (start_cond) begin
      bus_next = SSRW_BUS_STARTED;
    end else begin
      case (bus_reg)
        SSRW_BUS_IDLE: begin
          bus_next = SSRW_BUS_IDLE;
        end
        SSRW_BUS_STARTED: begin
          if (stop_cond) begin
            bus_next = SSRW_BUS_IDLE;
          end else if (scl_fall) begin
            bus_next = SSRW_BUS_CLOCKED; // R1
          end
        end
        SSRW_BUS_CLOCKED: begin
          if (stop_cond) begin
            bus_next = SSRW_BUS_IDLE;
          end
        end
        default: begin
          bus_next = SSRW_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      bus_reg      <= SSRW_BUS_IDLE;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      bus_reg      <= bus_next;
    end
  end

  // Watchdog timer
  assign wd_hold = !sys_n_reg || restart || wd_sel_reg == `SSRW_WD_SEL_OFF;
  assign wd_tick = wd_pre_reg == TICK_LAST;

  always_comb begin
    wd_pre_next = step_pre(wd_pre_reg, wd_hold || wd_cnt_reg == 11'h000);
    wd_cnt_next = wd_cnt_reg;
    wdo_n_next  = wdo_n_reg;
    if (wd_hold) begin
      wd_cnt_next = wdog_ms(wd_sel_reg); // R15
      wdo_n_next  = 1'b1; // R1
    end else if (wd_cnt_reg == 11'h000) begin
      wdo_n_next  = 1'b0; // R2 R3
    end else if (wd_tick) begin
      wd_cnt_next = wd_cnt_reg - 11'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wd_pre_reg <= 15'h0000;
      wd_cnt_reg <= `SSRW_WD_T0_MS;
      wdo_n_reg  <= 1'b1;
    end else begin
      wd_pre_reg <= wd_pre_next;
      wd_cnt_reg <= wd_cnt_next;
      wdo_n_reg  <= wdo_n_next;
    end
  end

  // Control bits, blocked while write-protect is high
  always_comb begin
    wd_sel_next  = wd_sel_reg;
    rst_sel_next = rst_sel_reg;
    rej_next     = i_ctrl_write && wp_s; // R4
    if (i_ctrl_write && !wp_s) begin
      wd_sel_next  = i_ctrl_wdog_period; // R15
      rst_sel_next = i_ctrl_reset_timeout;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wd_sel_reg  <= `SSRW_WD_SEL_RST;
      rst_sel_reg <= `SSRW_RST_SEL_RST;
      rej_reg     <= 1'b0;
    end else begin
      wd_sel_reg  <= wd_sel_next;
      rst_sel_reg <= rst_sel_next;
      rej_reg     <= rej_next;
    end
  end

  assign o_system_reset_n       = sys_n_reg;
  assign o_early_low_supply_n   = main_ok_s; // R13
  assign o_second_supply_fail_n = in_s[`SSRW_IN_SECOND]; // R9
  assign o_third_supply_fail_n  = in_s[`SSRW_IN_THIRD]; // R10 R11
  assign o_watchdog_timeout_n   = wdo_n_reg; // R3
  assign o_watchdog_oe_n        = wdo_n_reg; // R3
  assign o_write_rejected       = rej_reg;

  // Checks
  sequence s_bus_restart;
    bus_reg == SSRW_BUS_CLOCKED && stop_cond;
  endsequence

  sequence s_wd_reloaded;
    ##1 (o_watchdog_timeout_n && wd_cnt_reg == wdog_ms($past(wd_sel_reg)));
  endsequence

  a_por_reset: assert property (@(posedge i_core_clk) // R5
    !i_reset_n |=> !o_system_reset_n)
    else $error("reset not asserted on power-up");
  a_manual_hold: assert property (@(posedge i_core_clk) // R7
    disable iff (!i_reset_n) !mr_db_reg |=> !o_system_reset_n [*2])
    else $error("manual reset not held");
  a_main_low: assert property (@(posedge i_core_clk) // R8
    disable iff (!i_reset_n) !main_ok_s |=> !o_system_reset_n)
    else $error("low main supply not asserting reset");
  a_release_gate: assert property (@(posedge i_core_clk) // R6
    disable iff (!i_reset_n)
    $rose(o_system_reset_n) |-> $past(rst_cnt_reg == 11'h000 && !cause))
    else $error("reset released before timeout");
  a_count_reload: assert property (@(posedge i_core_clk) // R17
    disable iff (!i_reset_n)
    cause |=> rst_cnt_reg == reset_ms($past(rst_sel_reg)))
    else $error("reset timeout not restarted");
  a_early_low_supply_n_early: assert property (@(posedge i_core_clk) // R13
    disable iff (!i_reset_n)
    !o_early_low_supply_n |=> !o_system_reset_n)
    else $error("early low supply not ahead of reset");
  a_wd_restart: assert property (@(posedge i_core_clk) // R1
    disable iff (!i_reset_n) s_bus_restart |-> s_wd_reloaded)
    else $error("bus activity did not restart watchdog");
  a_wd_expire: assert property (@(posedge i_core_clk) // R2
    disable iff (!i_reset_n)
    (!wd_hold && wd_cnt_reg == 11'h000) |=> !o_watchdog_timeout_n)
    else $error("watchdog expiry not signalled");
  a_wp_block: assert property (@(posedge i_core_clk) // R4
    disable iff (!i_reset_n) (i_ctrl_write && wp_s) |=>
    (wd_sel_reg == $past(wd_sel_reg) && o_write_rejected))
    else $error("protected write accepted");
  a_wd_select: assert property (@(posedge i_core_clk) // R15
    disable iff (!i_reset_n) (i_ctrl_write && !wp_s) |=>
    wd_sel_reg == $past(i_ctrl_wdog_period))
    else $error("watchdog period not taken");
endmodule : ssrw_supervisor

// ===== test/ssrw_bus_host.sv
// Two-wire bus master model sending watchdog restart sequences
`timescale 1ns/100ps
module ssrw_bus_host (
  input  wire logic i_core_clk,
  input  wire logic i_go,
  input  wire logic i_slow,
  input  wire logic i_skip_clock,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_busy
);
  int step = 0;
  int hold = 0;
  initial begin
    o_scl  = 1'b1;
    o_sda  = 1'b1;
    o_busy = 1'b0;
  end
  // Idle lines are driven high by the model in place of pull-ups
  always @(negedge i_core_clk) begin
    if (!o_busy && i_go) begin
      o_busy <= 1'b1;
      o_sda  <= 1'b0;
      step   <= 1;
      hold   <= 0;
    end else if (o_busy && hold < (i_slow ? 40 : 8)) begin
      hold <= hold + 1;
    end else if (o_busy) begin
      hold <= 0;
      step <= step + 1;
      case (step)
        1: o_scl <= i_skip_clock;
        2: o_scl <= 1'b1;
        3: o_sda <= 1'b1;
        default: o_busy <= 1'b0;
      endcase
    end
  end
endmodule : ssrw_bus_host

// ===== test/ssrw_supervisor_tb_top.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/100ps
module ssrw_supervisor_tb_top;
  import ssrw_pkg::*;
  localparam int TK = 10;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      main_ok = 1'b1, sec = 1'b1, thr = 1'b1, man_n = 1'b1;
  logic      wp = 1'b0, wr = 1'b0, go = 1'b0, slow = 1'b0, skip = 1'b0;
  ssrw_sel_t wd_sel = 2'h0;
  ssrw_sel_t rst_sel = 2'h0;
  logic      scl, sda, busy, rst_o, low_o, f2, f3, watchdog_timeout_n, oe_n, rej;
  int        err_count = 0;
  int        checks_done = 0;
  int        n;
  // Rows: {main, second, third, exp reset, exp low, exp fail2, exp fail3}
  logic [6:0] rows [7] = '{7'h7F, 7'h6E, 7'h5D, 7'h33, 7'h00, 7'h22, 7'h77};
  always #20 clk = ~clk;

  ssrw_bus_host host (.i_core_clk(clk), .i_go(go), .i_slow(slow),
    .i_skip_clock(skip), .o_scl(scl), .o_sda(sda), .o_busy(busy));

  ssrw_supervisor #(.TICK_CYCLES(TK)) dut (.i_core_clk(clk),
    .i_reset_n(rst_n), .i_main_supply_ok(main_ok),
    .i_second_supply_sense(sec), .i_third_supply_sense(thr),
    .i_manual_reset_n(man_n), .i_scl(scl), .i_sda(sda),
    .i_write_protect(wp), .i_ctrl_write(wr), .i_ctrl_wdog_period(wd_sel),
    .i_ctrl_reset_timeout(rst_sel), .o_system_reset_n(rst_o),
    .o_early_low_supply_n(low_o), .o_second_supply_fail_n(f2),
    .o_third_supply_fail_n(f3), .o_watchdog_timeout_n(watchdog_timeout_n),
    .o_watchdog_oe_n(oe_n), .o_write_rejected(rej));

  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Counts cycles until reset (0) or watchdog (1) output reaches val
  task automatic wait_on(input int which, input logic val, input int lim);
    n = 0;
    while ((which ? watchdog_timeout_n : rst_o) !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_on

  task automatic restart(input logic s, input logic k);
    slow <= s;
    skip <= k;
    go   <= 1'b1;
    @(negedge clk);
    go   <= 1'b0;
    n = 0;
    while (busy !== 1'b0 || n < 2) begin
      @(negedge clk);
      n++;
    end
  endtask : restart

  // Counts reject pulses over the three cycles after a write
  task automatic wr_sel(input ssrw_sel_t v, input int exp_rej);
    int hits;
    hits = 0;
    wr     = 1'b1;
    wd_sel = v;
    @(negedge clk);
    wr = 1'b0;
    repeat (3) begin
      if (rej === 1'b1) hits++;
      @(negedge clk);
    end
    chk(hits, exp_rej);
  endtask : wr_sel

  initial begin
    cyc(10);
    chk({rst_o, watchdog_timeout_n, rej}, 3'h2);
    cyc(6);
    rst_n = 1'b1;
    wait_on(0, 1'b1, 700);
    chk(n >= 490 && n <= 515, 1);
    for (int i = 0; i < 7; i++) begin
      {main_ok, sec, thr} = rows[i][6:4];
      cyc(6);
      chk({rst_o, low_o, f2, f3}, rows[i][3:0]);
    end
    wait_on(0, 1'b1, 700);
    chk(n >= 480 && n <= 515, 1);
    main_ok = 1'b0;
    cyc(10);
    main_ok = 1'b1;
    cyc(300);
    chk(rst_o, 0);
    main_ok = 1'b0;
    cyc(10);
    main_ok = 1'b1;
    wait_on(0, 1'b1, 700);
    chk(n >= 490 && n <= 515, 1);
    man_n = 1'b0;
    cyc(60);
    chk(rst_o, 0);
    man_n = 1'b1;
    wait_on(0, 1'b1, 800);
    chk(n >= 500 && n <= 570, 1);
    restart(1'b0, 1'b0);
    wait_on(1, 1'b0, 400);
    chk(n >= 220 && n <= 270, 1);
    chk({watchdog_timeout_n, oe_n}, 2'h0);
    restart(1'b0, 1'b1);
    cyc(6);
    chk(watchdog_timeout_n, 0);
    restart(1'b1, 1'b0);
    cyc(6);
    chk({watchdog_timeout_n, oe_n}, 2'h3);
    repeat (4) begin
      restart(1'b0, 1'b0);
      cyc(100);
      chk(watchdog_timeout_n, 1);
    end
    wr_sel(2'h3, 0);
    restart(1'b0, 1'b0);
    wait_on(1, 1'b0, 400);
    chk(n, 400);
    wp = 1'b1;
    cyc(6);
    wr_sel(2'h0, 1);
    restart(1'b0, 1'b0);
    wait_on(1, 1'b0, 400);
    chk(n, 400);
    wp = 1'b0;
    cyc(6);
    wr_sel(2'h0, 0);
    restart(1'b0, 1'b0);
    wait_on(1, 1'b0, 400);
    chk(n >= 220 && n <= 270, 1);
    rst_sel = 2'h1;
    wr_sel(2'h3, 0);
    main_ok = 1'b0;
    cyc(10);
    main_ok = 1'b1;
    wait_on(0, 1'b1, 2200);
    chk(n >= 1990 && n <= 2015, 1);
    rst_n = 1'b0;
    cyc(4);
    chk({rst_o, watchdog_timeout_n, oe_n, rej}, 4'h6);
    rst_n = 1'b1;
    cyc(4);
    chk(rst_o, 0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule : ssrw_supervisor_tb_top
